// ==== core/guard_defs.vh ====
`ifndef GUARD_DEFS_VH
`define GUARD_DEFS_VH

// ==========================================================
// clock
// ==========================================================
`define CLK_KHZ          100000

// ==========================================================
// timing, in milliseconds as specified
// ==========================================================
`define T_INIT_MS        1000
`define T_PRESS_MIN_MS   200
`define T_PRESS_MAX_MS   5000
`define T_FB_SETTLE_MS   50

// ==========================================================
// timing, in clock cycles
// ==========================================================
`define INIT_CYCLES      (`T_INIT_MS * `CLK_KHZ)
`define PRESS_MIN_CYCLES (`T_PRESS_MIN_MS * `CLK_KHZ)
`define PRESS_MAX_CYCLES (`T_PRESS_MAX_MS * `CLK_KHZ)
`define FB_SETTLE_CYCLES (`T_FB_SETTLE_MS * `CLK_KHZ)

// ==========================================================
// operating state codes
// ==========================================================
`define ST_INIT          3'h0
`define ST_WAIT_START    3'h1
`define ST_RUN           3'h2
`define ST_STOP          3'h3
`define ST_ERROR         3'h4

// ==========================================================
// reset value and counter width
// ==========================================================
`define MODE_MANUAL_RST  1'b1
`define COUNT_W          32

`endif

// ==== core/start_press_validator.v ====
`timescale 1ns/1ps
`include "guard_defs.vh"

module start_press_validator #(
  parameter [31:0] PRESS_MIN = `PRESS_MIN_CYCLES,
  parameter [31:0] PRESS_MAX = `PRESS_MAX_CYCLES
) (
  input  wire ref_clk,      // system clock
  input  wire resetn,       // async reset, active low
  input  wire start_in,     // start input, 1 = active level
  output wire start_accept, // one-cycle pulse on valid release
  output wire start_expired // level: current press held too long
);

  reg        armed_r;
  reg        holding_r;
  reg [31:0] hold_cnt_r;
  reg        accept_r;

  // ==========================================================
  // press-and-release timing
  // ==========================================================
  // armed only after the input is seen low, so a button stuck
  // active at power-up never counts as a press
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_r    <= 1'b0;
      holding_r  <= 1'b0;
      hold_cnt_r <= 32'h0;
      accept_r   <= 1'b0;
    end else begin
      accept_r <= 1'b0;
      if (!start_in) begin
        armed_r   <= 1'b1;
        holding_r <= 1'b0;
        // low-high-low complete, check the active phase
        if (holding_r && hold_cnt_r >= PRESS_MIN &&
            hold_cnt_r <= PRESS_MAX) begin
          accept_r <= 1'b1;
        end
      end else if (armed_r && !holding_r) begin
        holding_r  <= 1'b1;
        hold_cnt_r <= 32'h1;
      end else if (holding_r && hold_cnt_r <= PRESS_MAX) begin
        // saturate one past the limit: late release ignored
        hold_cnt_r <= hold_cnt_r + 32'h1;
      end
    end
  end

  assign start_accept  = accept_r;
  assign start_expired = holding_r && (hold_cnt_r > PRESS_MAX);

endmodule // start_press_validator

// ==== core/contactor_feedback_monitor.v ====
`timescale 1ns/1ps
`include "guard_defs.vh"

module contactor_feedback_monitor #(
  parameter [31:0] SETTLE = `FB_SETTLE_CYCLES
) (
  input  wire ref_clk,       // system clock
  input  wire resetn,        // async reset, active low
  input  wire outputs_on,    // commanded state of the outputs
  input  wire first_nc,      // first_contactor nc, 1 = closed
  input  wire second_nc,     // second_contactor nc, 1 = closed
  output wire released,      // both contactors show released
  output wire feedback_fault // sticky until power-up
);

  reg        on_d_r;
  reg [31:0] bad_cnt_r;
  reg        fault_r;
  reg        released_r;
  wire       mismatch;

  // nc contacts must be open while driven, closed while off
  assign mismatch = (first_nc != second_nc) ||
                    (first_nc == outputs_on);

  // ==========================================================
  // settle window and fault latch
  // ==========================================================
  // the window restarts on every command change, so contactor
  // travel time is not mistaken for a weld or a broken wire
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      on_d_r     <= 1'b0;
      bad_cnt_r  <= 32'h0;
      fault_r    <= 1'b0;
      released_r <= 1'b0;
    end else begin
      on_d_r     <= outputs_on;
      released_r <= first_nc && second_nc;
      if (outputs_on != on_d_r || !mismatch) begin
        bad_cnt_r <= 32'h0;
      end else if (bad_cnt_r < SETTLE) begin
        bad_cnt_r <= bad_cnt_r + 32'h1;
      end else begin
        fault_r <= 1'b1;
      end
    end
  end

  assign released       = released_r;
  assign feedback_fault = fault_r;

endmodule // contactor_feedback_monitor

// ==== core/guard_start_restart_control.v ====
`timescale 1ns/1ps
`include "guard_defs.vh"

module guard_start_restart_control #(
  parameter [31:0] INIT_CYCLES = `INIT_CYCLES,
  parameter [31:0] PRESS_MIN   = `PRESS_MIN_CYCLES,
  parameter [31:0] PRESS_MAX   = `PRESS_MAX_CYCLES,
  parameter [31:0] FB_SETTLE   = `FB_SETTLE_CYCLES
) (
  input  wire       ref_clk,              // 100 mhz clock
  input  wire       resetn,               // power-up reset, low
  input  wire       tag_detect,           // a tag answers in zone
  input  wire       tag_code_ok,          // its code is the paired one
  input  wire       manual_mode_sel,      // strap: 1 manual, 0 auto
  input  wire       self_test_fail,       // internal self test fault
  input  wire       start_in,             // start button, 1 active
  input  wire       first_contactor_nc,   // first nc feedback
  input  wire       second_contactor_nc,  // second nc feedback
  output wire       redundant_safety_output_a, // channel a, 1 on
  output wire       redundant_safety_output_b, // channel b, 1 on
  output wire [2:0] op_state,             // operating state code
  output wire       waiting_start,        // ready, needs start
  output wire       tag_error,            // wrong code seen
  output wire       feedback_fault,       // contactor fault seen
  output wire       internal_fault,       // self test fault seen
  output wire       start_too_long        // press held past limit
);

  // ==========================================================
  // declarations
  // ==========================================================
  // state machine
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  // power-up phase and mode strap
  reg  [31:0] init_cnt_r;
  reg         init_done_r;
  reg         mode_manual_r;
  // tag qualification and sticky faults
  reg         tag_ok_r;
  reg         tag_err_r;
  reg         self_fail_r;
  // redundant outputs
  reg         out_a_r;
  reg         out_b_r;
  reg         out_nxt;
  // status flops
  reg         waiting_r;
  reg         fb_fault_r;
  reg         too_long_r;
  reg  [2:0]  state_out_r;
  // sub-block results
  wire        start_accept;
  wire        start_expired;
  wire        fb_released;
  wire        fb_fault;
  wire        any_fault;

  // ==========================================================
  // state codes
  // ==========================================================
  // binary codes shared with op_state, so the status pins read
  // the same numbers as the state register
  localparam [2:0] S_INIT  = `ST_INIT;
  localparam [2:0] S_WAIT  = `ST_WAIT_START;
  localparam [2:0] S_RUN   = `ST_RUN;
  localparam [2:0] S_STOP  = `ST_STOP;
  localparam [2:0] S_ERROR = `ST_ERROR;

  // ==========================================================
  // helpers
  // ==========================================================
  // one place decides whether the outputs may be switched on;
  // a fault or an open contactor keeps them off even with a tag
  function run_allowed;
    input tag_ok;
    input fault;
    input released;
    begin
      run_allowed = tag_ok && !fault && released;
    end
  endfunction

  // ==========================================================
  // start command and contactor feedback
  // ==========================================================
  // press timing lives apart so its counter can be tested alone
  start_press_validator #(
    .PRESS_MIN (PRESS_MIN),
    .PRESS_MAX (PRESS_MAX)
  ) u_start (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .start_in      (start_in),
    .start_accept  (start_accept),
    .start_expired (start_expired)
  );

  // the monitor watches channel a; b is the same decision
  contactor_feedback_monitor #(
    .SETTLE (FB_SETTLE)
  ) u_feedback (
    .ref_clk        (ref_clk),
    .resetn         (resetn),
    .outputs_on     (out_a_r),
    .first_nc       (first_contactor_nc),
    .second_nc      (second_contactor_nc),
    .released       (fb_released),
    .feedback_fault (fb_fault)
  );

  // ==========================================================
  // initialisation phase and mode strap
  // ==========================================================
  // the strap is caught by the clock during init, never by the
  // reset itself; it is frozen once init ends so a loose wire
  // cannot flip auto/manual while the machine is running;
  // init length is a parameter so a bench can shorten it
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_cnt_r    <= 32'h0;
      init_done_r   <= 1'b0;
      mode_manual_r <= `MODE_MANUAL_RST;
    end else if (!init_done_r) begin
      mode_manual_r <= manual_mode_sel;
      if (init_cnt_r >= INIT_CYCLES - 32'h1) begin
        init_done_r <= 1'b1;
      end else begin
        init_cnt_r <= init_cnt_r + 32'h1;
      end
    end
  end

  // ==========================================================
  // tag qualification and fault latches
  // ==========================================================
  // a foreign code latches until the next power-up; only a
  // fresh reset clears it, there is no software escape;
  // tag_ok_r is the single present-and-paired decision
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tag_ok_r    <= 1'b0;
      tag_err_r   <= 1'b0;
      self_fail_r <= 1'b0;
    end else begin
      tag_ok_r <= tag_detect && tag_code_ok;
      if (tag_detect && !tag_code_ok) begin
        tag_err_r <= 1'b1;
      end
      if (self_test_fail) begin
        self_fail_r <= 1'b1;
      end
    end
  end

  // every fault source ends in the same latched error state
  assign any_fault = tag_err_r || self_fail_r || fb_fault;

  // ==========================================================
  // operating state machine
  // ==========================================================
  // a fault wins over every other condition, so a fault seen in
  // the same cycle as a valid start still ends in error
  always @* begin
    state_nxt = state_r;
    case (state_r)
      // power-up phase, outputs held off the whole time
      S_INIT: begin
        if (any_fault) begin
          state_nxt = S_ERROR;
        end else if (init_done_r) begin
          if (mode_manual_r) begin
            state_nxt = S_WAIT;
          end else if (run_allowed(tag_ok_r, any_fault,
                                   fb_released)) begin
            state_nxt = S_RUN;
          end else begin
            state_nxt = S_STOP;
          end
        end
      end
      // manual mode only: ready, waiting for a monitored start
      S_WAIT: begin
        if (any_fault) begin
          state_nxt = S_ERROR;
        end else if (start_accept &&
                     run_allowed(tag_ok_r, any_fault,
                                 fb_released)) begin
          state_nxt = S_RUN;
        end
      end
      // outputs on; tag loss drops them in either mode
      S_RUN: begin
        if (any_fault) begin
          state_nxt = S_ERROR;
        end else if (!tag_ok_r) begin
          state_nxt = S_STOP;
        end
      end
      // auto rejoins run by itself, manual needs a new start
      S_STOP: begin
        if (any_fault) begin
          state_nxt = S_ERROR;
        end else if (!mode_manual_r) begin
          if (run_allowed(tag_ok_r, any_fault, fb_released)) begin
            state_nxt = S_RUN;
          end
        end else if (start_accept &&
                     run_allowed(tag_ok_r, any_fault,
                                 fb_released)) begin
          // a press made while the door was open is not kept
          state_nxt = S_RUN;
        end
      end
      // only a new power-up leaves error
      S_ERROR: begin
        state_nxt = S_ERROR;
      end
      // unused codes are treated as a fault
      default: begin
        state_nxt = S_ERROR;
      end
    endcase
  end

  // outputs only on while the next state is run; taken from
  // state_nxt so pins and op_state change on the same edge
  always @* begin
    out_nxt = (state_nxt == S_RUN);
  end

  // state register
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // redundant outputs
  // ==========================================================
  // two separate flops so one stuck channel is not shared by
  // the other; both follow the same decision each cycle
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else begin
      out_a_r <= out_nxt;
      out_b_r <= out_nxt;
    end
  end

  // ==========================================================
  // status outputs
  // ==========================================================
  // registered copies; feedback_fault trails the monitor's
  // latch by one edge, the edge on which the outputs drop
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      waiting_r   <= 1'b0;
      fb_fault_r  <= 1'b0;
      too_long_r  <= 1'b0;
      state_out_r <= S_INIT;
    end else begin
      waiting_r   <= mode_manual_r &&
                     (state_nxt == S_WAIT ||
                      state_nxt == S_STOP);
      fb_fault_r  <= fb_fault;
      too_long_r  <= start_expired;
      state_out_r <= state_nxt;
    end
  end

  // ==========================================================
  // pin drivers
  // ==========================================================
  // each pin is a bare flop output, nothing sits after the flops
  assign redundant_safety_output_a = out_a_r;
  assign redundant_safety_output_b = out_b_r;
  assign op_state                  = state_out_r;
  assign waiting_start             = waiting_r;
  assign tag_error                 = tag_err_r;
  assign feedback_fault            = fb_fault_r;
  assign internal_fault            = self_fail_r;
  assign start_too_long            = too_long_r;

endmodule // guard_start_restart_control

// ==== test/guard_checker.sv ====
`timescale 1ns/1ps
// ==========================================================
// port checker for the start and restart sequencer
module guard_checker #(
  parameter [31:0] INIT_CYCLES = 32'd20,
  parameter [31:0] PRESS_MIN   = 32'd5,
  parameter [31:0] PRESS_MAX   = 32'd20,
  parameter [31:0] FB_SETTLE   = 32'd4
) (
  input wire       ref_clk,                   // clock
  input wire       resetn,                    // power-up reset
  input wire       tag_detect,                // tag in zone
  input wire       tag_code_ok,               // paired code
  input wire       manual_mode_sel,           // 1 manual
  input wire       start_in,                  // start button
  input wire       first_contactor_nc,        // first nc
  input wire       second_contactor_nc,       // second nc
  input wire       redundant_safety_output_a, // channel a
  input wire       redundant_safety_output_b, // channel b
  input wire [2:0] op_state,                  // state code
  input wire       tag_error,                 // wrong code
  input wire       feedback_fault,            // contactor fault
  input wire       internal_fault,            // self test fault
  input wire       start_too_long             // press too long
);
  wire        on = redundant_safety_output_a;
  reg         start_d_r;
  reg  [7:0]  rel_r;
  reg  [31:0] hi_r;
  reg  [31:0] bad_r;
  // release age, press length, mismatch age; counters avoid long repeats
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_d_r <= 1'b0;
      rel_r     <= 8'hff;
      hi_r      <= 32'h0;
      bad_r     <= 32'h0;
    end else begin
      start_d_r <= start_in;
      rel_r     <= (start_d_r && !start_in) ? 8'h0 :
                   (rel_r == 8'hff) ? rel_r : rel_r + 8'h1;
      hi_r      <= start_in ? hi_r + 32'h1 : 32'h0;
      bad_r     <= (on && (first_contactor_nc || second_contactor_nc)) ?
                   bad_r + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence run_tag_lost;
    op_state == 3'h2 && !tag_detect;
  endsequence
  sequence outs_drop;
    ##[1:2] !on;
  endsequence
  chan_equal_a: assert property (on == redundant_safety_output_b)
    else $error("safety channels differ");
  init_off_a: assert property (op_state == 3'h0 |-> !on)
    else $error("output on during init");
  on_only_run_a: assert property (on == (op_state == 3'h2))
    else $error("output on outside run");
  tag_loss_a: assert property (run_tag_lost |-> outs_drop)
    else $error("output stayed on after tag loss");
  manual_start_a: assert property ($rose(on) && manual_mode_sel |->
    rel_r <= 8'h3) else $error("manual run without start release");
  fb_need_a: assert property ($rose(on) |->
    $past(first_contactor_nc) && $past(second_contactor_nc))
    else $error("output on with contactor not released");
  error_hold_a: assert property (op_state == 3'h4 |=>
    op_state == 3'h4) else $error("error state left");
  wrong_tag_a: assert property (tag_detect && !tag_code_ok |->
    ##[1:3] tag_error) else $error("wrong tag not flagged");
  fault_off_a: assert property (tag_error || feedback_fault ||
    internal_fault |-> ##2 !on) else $error("output on after fault");
  too_long_a: assert property (hi_r > PRESS_MAX + 32'd2 |->
    start_too_long) else $error("long press not flagged");
  fb_stuck_a: assert property (bad_r > FB_SETTLE + 32'd2 |->
    feedback_fault) else $error("contactor mismatch not flagged");
endmodule // guard_checker

bind guard_start_restart_control guard_checker #(
  .INIT_CYCLES(INIT_CYCLES), .PRESS_MIN(PRESS_MIN),
  .PRESS_MAX(PRESS_MAX), .FB_SETTLE(FB_SETTLE)
) i_guard_checker (
  .ref_clk, .resetn, .tag_detect, .tag_code_ok, .manual_mode_sel,
  .start_in, .first_contactor_nc, .second_contactor_nc,
  .redundant_safety_output_a, .redundant_safety_output_b, .op_state,
  .tag_error, .feedback_fault, .internal_fault, .start_too_long
);

// ==== test/contactor_pair_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// two force-guided contactors with selectable stuck contacts
module contactor_pair_model (
  input  wire       ref_clk,    // clock
  input  wire       out_a,      // coil of first contactor
  input  wire       out_b,      // coil of second contactor
  input  wire [1:0] fault_kind, // 0 ok,1 both stuck,2 second,3 first open
  output reg        first_nc,   // 1 = closed, released
  output reg        second_nc   // 1 = closed, released
);
  reg a_d = 1'b0;
  reg b_d = 1'b0;
  initial first_nc = 1'b1;
  initial second_nc = 1'b1;
  // contacts lag the coils two cycles, well inside the settle window
  always @(posedge ref_clk) begin
    a_d       <= out_a;
    b_d       <= out_b;
    first_nc  <= (fault_kind == 2'h3) ? 1'b0 :
                 (fault_kind == 2'h1) ? 1'b1 : !a_d;
    second_nc <= (fault_kind == 2'h1 || fault_kind == 2'h2) ? 1'b1 :
                 !b_d;
  end
endmodule // contactor_pair_model

// ==== test/test_guard_start_restart_control.sv ====
`timescale 1ns/1ps
// ==========================================================
// bench: drivers note expected state changes, a monitor checks them
module test_guard_start_restart_control;
  localparam [31:0] INIT = 32'd20;
  localparam [31:0] PMIN = 32'd5;
  localparam [31:0] PMAX = 32'd20;
  localparam [31:0] FBS  = 32'd4;
  reg         ref_clk = 1'b0;
  reg         resetn = 1'b0;
  reg         tag_detect = 1'b0;
  reg         tag_code_ok = 1'b0;
  reg         manual_mode_sel = 1'b0;
  reg         self_test_fail = 1'b0;
  reg         start_in = 1'b0;
  reg  [1:0]  fault_kind = 2'h0;
  wire        first_nc, second_nc, out_a, out_b, waiting_start;
  wire        tag_error, feedback_fault, internal_fault, start_too_long;
  wire [2:0]  op_state;
  reg  [4:0]  notes[$];
  reg  [2:0]  prev_state = 3'h0;
  reg  [31:0] rnd = 32'h4b83;
  integer     fail_count = 0;
  integer     comparisons = 0;
  integer     init_n;
  integer     k;
  guard_start_restart_control #(.INIT_CYCLES(INIT), .PRESS_MIN(PMIN),
    .PRESS_MAX(PMAX), .FB_SETTLE(FBS)) i_guard_start_restart_control (
    .ref_clk(ref_clk), .resetn(resetn), .tag_detect(tag_detect),
    .tag_code_ok(tag_code_ok), .manual_mode_sel(manual_mode_sel),
    .self_test_fail(self_test_fail), .start_in(start_in),
    .first_contactor_nc(first_nc), .second_contactor_nc(second_nc),
    .redundant_safety_output_a(out_a), .redundant_safety_output_b(out_b),
    .op_state(op_state), .waiting_start(waiting_start),
    .tag_error(tag_error), .feedback_fault(feedback_fault),
    .internal_fault(internal_fault), .start_too_long(start_too_long));
  contactor_pair_model i_contactor_pair_model (.ref_clk(ref_clk),
    .out_a(out_a), .out_b(out_b), .fault_kind(fault_kind),
    .first_nc(first_nc), .second_nc(second_nc));
  // free-running 100 mhz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [8*10:1] name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // bounded wait until every noted change has been seen
  task wait_notes(input integer lim);
    integer i;
    begin
      for (i = 0; i < lim && notes.size() > 0; i = i + 1)
        @(negedge ref_clk);
      if (notes.size() > 0) begin
        fail_count = fail_count + 1;
        $display("ERROR timeout expected %h", notes[0]);
        end_sim;
      end
    end
  endtask
  task power_up(input mode, input code, input [4:0] exp);
    integer i;
    begin
      if (prev_state !== 3'h0) notes.push_back(5'h00);
      resetn = 1'b0;
      fault_kind = 2'h0;
      // random levels while reset holds every latch clear
      for (i = 0; i < 11; i = i + 1) begin
        rnd = lfsr(rnd);
        {manual_mode_sel, tag_detect, tag_code_ok} = rnd[2:0];
        {self_test_fail, start_in} = rnd[4:3];
        @(negedge ref_clk);
      end
      manual_mode_sel = mode;
      tag_detect = 1'b1;
      tag_code_ok = code;
      self_test_fail = 1'b0;
      start_in = 1'b0;
      @(negedge ref_clk);
      notes.push_back(exp);
      resetn = 1'b1;
      init_n = 0;
      while (op_state === 3'h0 && init_n < INIT + 20) begin
        @(negedge ref_clk);
        init_n = init_n + 1;
      end
      wait_notes(60);
    end
  endtask
  task press(input [31:0] n);
    begin
      start_in = 1'b1;
      repeat (n) @(negedge ref_clk);
      start_in = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  // each state change takes the oldest note; none left means a mismatch
  initial begin
    forever begin
      @(negedge ref_clk);
      if (op_state !== prev_state) begin
        prev_state = op_state;
        chk("state", {out_a, out_b, op_state},
            notes.size() ? notes.pop_front() : 5'h1f);
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    power_up(1'b0, 1'b1, 5'h1a);
    chk("init min", init_n >= INIT, 1'b1);
    chk("init max", init_n <= INIT + 4, 1'b1);
    notes.push_back(5'h03);
    tag_detect = 1'b0;
    wait_notes(60);
    // door open: random presses, codes and strap levels change nothing
    for (k = 0; k < 40; k = k + 1) begin
      rnd = lfsr(rnd);
      {manual_mode_sel, tag_code_ok, start_in} = rnd[2:0];
      @(negedge ref_clk);
      chk("no wait", waiting_start, 1'b0);
    end
    manual_mode_sel = 1'b0;
    tag_code_ok = 1'b1;
    start_in = 1'b0;
    @(negedge ref_clk);
    notes.push_back(5'h1a);
    tag_detect = 1'b1;
    wait_notes(60);
    $display("auto start test done");
    power_up(1'b1, 1'b1, 5'h01);
    chk("waiting", waiting_start, 1'b1);
    press(PMIN - 1);
    repeat (4) @(negedge ref_clk);
    chk("short", op_state, 3'h1);
    start_in = 1'b1;
    repeat (PMAX + 3) @(negedge ref_clk);
    chk("too long", start_too_long, 1'b1);
    press(1);
    repeat (4) @(negedge ref_clk);
    chk("long", op_state, 3'h1);
    rnd = lfsr(rnd);
    notes.push_back(5'h1a);
    press(PMIN + rnd % (PMAX - PMIN + 1));
    wait_notes(60);
    notes.push_back(5'h03);
    tag_detect = 1'b0;
    wait_notes(60);
    press(PMIN);
    tag_detect = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("restart", op_state, 3'h3);
    notes.push_back(5'h1a);
    press(PMAX);
    wait_notes(60);
    $display("manual start test done");
    // stuck pair, stuck second, first open before start
    for (k = 1; k < 4; k = k + 1) begin
      power_up(1'b1, 1'b1, 5'h01);
      fault_kind = k;
      if (k < 3) notes.push_back(5'h1a);
      notes.push_back(5'h04);
      press(PMIN);
      wait_notes(60);
      chk("fb fault", feedback_fault, 1'b1);
    end
    $display("feedback test done");
    power_up(1'b0, 1'b0, 5'h04);
    chk("tag err", tag_error, 1'b1);
    tag_code_ok = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("latched", op_state, 3'h4);
    power_up(1'b0, 1'b1, 5'h1a);
    notes.push_back(5'h04);
    self_test_fail = 1'b1;
    wait_notes(60);
    chk("internal", internal_fault, 1'b1);
    $display("fault test done");
    chk("notes", notes.size(), 0);
    end_sim;
  end
endmodule // test_guard_start_restart_control
